// File: pkg/oms_regs.vh
/*
 register map constants of the mouse sensor test register bank.
 assumes inclusion by bare name from design files; definitions only.
*/
`ifndef OMS_REGS_VH
`define OMS_REGS_VH
`define OMS_ADDR_PRODUCT_IDENTIFIER 8'h00
`define OMS_ADDR_SILICON_REVISION 8'h01
`define OMS_ADDR_BUTTON_STATUS 8'h02
`define OMS_ADDR_MOTION_X_LOW 8'h03
`define OMS_ADDR_MOTION_Y_LOW 8'h04
`define OMS_ADDR_MOTION_XY_HIGH 8'h05
`define OMS_ADDR_WHEEL_COUNT 8'h06
`define OMS_ADDR_SURFACE_QUALITY 8'h07
`define OMS_ADDR_EXPOSURE_HIGH 8'h08
`define OMS_ADDR_EXPOSURE_LOW 8'h09
`define OMS_ADDR_PIXEL_MAXIMUM 8'h0A
`define OMS_ADDR_PIXEL_ACCUMULATION 8'h0B
`define OMS_ADDR_PIXEL_MINIMUM 8'h0C
`define OMS_ADDR_PIXEL_CAPTURE 8'h0D
`define OMS_ADDR_INVERTED_REVISION 8'h40
`define OMS_ADDR_NVM_CLOCK_SETTING 8'h42
`define OMS_ADDR_NVM_CONFIGURATION 8'h51
`define OMS_ADDR_NVM_ADDRESS 8'h52
`define OMS_ADDR_NVM_WRITE_DATA 8'h53
`define OMS_ADDR_NVM_CONTROL 8'h54
`define OMS_ADDR_NVM_RUN_STATUS 8'h56
`define OMS_ADDR_NVM_CONTROL_STATUS 8'h58
`define OMS_ADDR_USE_PROGRAMMED 8'hDF
`define OMS_ADDR_RESOLUTION 8'hE0
`define OMS_ADDR_PRODUCT_CODE_HI 8'hE2
`define OMS_ADDR_PRODUCT_CODE_LO 8'hE3
`define OMS_ADDR_VENDOR_CODE_HI 8'hE4
`define OMS_ADDR_VENDOR_CODE_LO 8'hE5
`define OMS_ADDR_PROGRAMMING_LOCK 8'hE8
// reset values
`define OMS_RST_ZERO 8'h00
`define OMS_RST_EXPOSURE_LOW 8'h32
`define OMS_RST_RESOLUTION 8'h04
// identity values: arbitrary, neutral
`define OMS_PRODUCT_ID_VALUE 8'h5A
`define OMS_SILICON_REV_VALUE 8'h03
`define OMS_PRODUCT_CODE_RESET 16'h1234
`define OMS_VENDOR_CODE_RESET 16'hABCD
// field layout
`define OMS_BUTTON_MSB 2
`define OMS_DELTA_MSB 11
`define OMS_DELTA_LOW_MSB 7
`define OMS_DELTA_HIGH_LSB 8
`endif

// File: core/oms_motion_mirror.v
/*
 motion mirror: captures the last reported delta x/y (12-bit two's complement)
 and holds y-low and xy-high at zero until the first x-low read after reset.
 assumes report strobe and read strobes synchronous to sys_clk.
*/
`include "oms_regs.vh"

module oms_motion_mirror (
    // clock and reset
    input wire sys_clk,
    input wire srst,
    // motion report side
    input wire report_load,
    input wire [11:0] report_dx,
    input wire [11:0] report_dy,
    // read side
    input wire read_x_low,
    input wire read_y_or_high,
    output reg [7:0] x_low_reg,
    output reg [7:0] y_low_reg,
    output reg [7:0] xy_high_reg
);

reg [11:0] dx_reg;
reg [11:0] dy_reg;
reg armed_reg;
wire armed_now;
wire [11:0] dx_now;
wire [11:0] dy_now;

// next-state view, so a y/high read right after the x-low read is already served
assign armed_now = armed_reg || read_x_low;
assign dx_now = report_load ? report_dx : dx_reg;
assign dy_now = report_load ? report_dy : dy_reg;

////////////////////////////////////////////////////////////////////////
always @(posedge sys_clk) begin
    if (srst) begin
        dx_reg <= 12'h000;
        dy_reg <= 12'h000;
        armed_reg <= 1'b0;
        x_low_reg <= `OMS_RST_ZERO;
        y_low_reg <= `OMS_RST_ZERO;
        xy_high_reg <= `OMS_RST_ZERO;
    end else begin
        if (report_load) begin
            // values already scaled and signed by the report path
            dx_reg <= report_dx;
            dy_reg <= report_dy;
        end
        x_low_reg <= dx_now[`OMS_DELTA_LOW_MSB:0];
        if (read_x_low) begin
            armed_reg <= 1'b1;
        end
        // without a prior x-low read the pair reads zero
        y_low_reg <= armed_now ? dy_now[`OMS_DELTA_LOW_MSB:0] : `OMS_RST_ZERO;
        xy_high_reg <= armed_now ? {dx_now[`OMS_DELTA_MSB:`OMS_DELTA_HIGH_LSB],
                                    dy_now[`OMS_DELTA_MSB:`OMS_DELTA_HIGH_LSB]} : `OMS_RST_ZERO;
        if (read_y_or_high && !read_x_low) begin
            armed_reg <= armed_reg;
        end
    end
end

endmodule

// File: core/oms_register_bank.v
/*
 test and configuration register bank reached by vendor register requests
 from the usb endpoint logic: one-cycle read or write strobe, 8-bit address,
 8-bit data; read data is registered one cycle later.
 assumes the usb core decodes requests and signals bus reset; supply loss
 arrives as a level from the power monitor.
*/
// Functional notes
// - register map reachable by host over usb
// - supply low or bus reset disables access
// - offset zero returns fixed product identifier
// - read-only 8-bit silicon revision code
// - buttons three two one in bits 2..0
// - x-low mirrors last reported delta x
// - deltas two's complement, scaled by resolution
// - product id, revision, status, motion read-only; nvm config, resolution, usb codes, lock writable
// - x-low read first else y/high zero
`include "oms_regs.vh"

module oms_register_bank (
    // clock and reset
    input wire sys_clk,
    input wire srst,
    // access disable sources
    input wire main_supply_ok,
    input wire usb_bus_reset,
    // register request from usb endpoint
    input wire reg_read,
    input wire reg_write,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    // register answer
    output reg [7:0] reg_rdata,
    output reg reg_rvalid,
    output reg reg_access_en,
    // debounced buttons
    input wire first_button_flag,
    input wire second_button_flag,
    input wire third_button_flag,
    // motion report path
    input wire report_load,
    input wire [11:0] report_dx,
    input wire [11:0] report_dy,
    input wire [7:0] wheel_in,
    // image statistics
    input wire [7:0] surface_quality_in,
    input wire [15:0] exposure_in,
    input wire [7:0] pixel_maximum_in,
    input wire [7:0] pixel_accumulation_in,
    input wire [7:0] pixel_minimum_in,
    input wire [7:0] pixel_capture_in,
    // nvm engine status
    input wire [7:0] nvm_run_status_in,
    input wire [7:0] nvm_control_status_in,
    // configuration out
    output reg [7:0] resolution_setting,
    output reg [7:0] use_programmed_settings,
    output reg [15:0] usb_product_code,
    output reg [15:0] usb_vendor_code,
    output reg [7:0] programming_lock,
    output reg [7:0] nvm_clock_setting,
    output reg [7:0] nvm_configuration,
    output reg [7:0] nvm_address,
    output reg [7:0] nvm_write_data,
    output reg [7:0] nvm_control
);

wire rd_ok;
wire wr_ok;
wire [7:0] x_low;
wire [7:0] y_low;
wire [7:0] xy_high;
reg [7:0] button_state_reg;
reg [7:0] rdata_next;
reg stats_valid_reg;

// access blocked while supply low or in usb reset
assign rd_ok = reg_read && main_supply_ok && !usb_bus_reset;
assign wr_ok = reg_write && main_supply_ok && !usb_bus_reset;

function is_addr;
    input [7:0] a;
    input [7:0] b;
    begin
        is_addr = (a == b);
    end
endfunction

////////////////////////////////////////////////////////////////////////
oms_motion_mirror u_mirror (
    .sys_clk(sys_clk),
    .srst(srst),
    .report_load(report_load),
    .report_dx(report_dx),
    .report_dy(report_dy),
    .read_x_low(rd_ok && is_addr(reg_addr, `OMS_ADDR_MOTION_X_LOW)),
    .read_y_or_high(rd_ok && (is_addr(reg_addr, `OMS_ADDR_MOTION_Y_LOW) ||
                              is_addr(reg_addr, `OMS_ADDR_MOTION_XY_HIGH))),
    .x_low_reg(x_low),
    .y_low_reg(y_low),
    .xy_high_reg(xy_high)
);

////////////////////////////////////////////////////////////////////////
// buttons sampled once a cycle; reserved bits stay zero
always @(posedge sys_clk) begin
    if (srst) begin
        button_state_reg <= `OMS_RST_ZERO;
        stats_valid_reg <= 1'b0;
    end else begin
        button_state_reg <= {5'h00, third_button_flag, second_button_flag, first_button_flag};
        stats_valid_reg <= 1'b1;
    end
end

////////////////////////////////////////////////////////////////////////
// read mux: unmapped space reads zero
always @* begin
    rdata_next = `OMS_RST_ZERO;
    case (reg_addr)
        `OMS_ADDR_PRODUCT_IDENTIFIER: rdata_next = `OMS_PRODUCT_ID_VALUE;
        `OMS_ADDR_SILICON_REVISION: rdata_next = `OMS_SILICON_REV_VALUE;
        `OMS_ADDR_BUTTON_STATUS: rdata_next = button_state_reg;
        `OMS_ADDR_MOTION_X_LOW: rdata_next = x_low;
        `OMS_ADDR_MOTION_Y_LOW: rdata_next = y_low;
        `OMS_ADDR_MOTION_XY_HIGH: rdata_next = xy_high;
        `OMS_ADDR_WHEEL_COUNT: rdata_next = wheel_in;
        `OMS_ADDR_SURFACE_QUALITY: rdata_next = surface_quality_in;
        `OMS_ADDR_EXPOSURE_HIGH: rdata_next = exposure_in[15:8];
        // stats inputs may be junk right after reset, so exposure low alone shows its reset value through the first cycle out of srst
        `OMS_ADDR_EXPOSURE_LOW: rdata_next = stats_valid_reg ? exposure_in[7:0] : `OMS_RST_EXPOSURE_LOW;
        `OMS_ADDR_PIXEL_MAXIMUM: rdata_next = {1'b0, pixel_maximum_in[6:0]};
        `OMS_ADDR_PIXEL_ACCUMULATION: rdata_next = pixel_accumulation_in;
        `OMS_ADDR_PIXEL_MINIMUM: rdata_next = pixel_minimum_in;
        `OMS_ADDR_PIXEL_CAPTURE: rdata_next = pixel_capture_in;
        `OMS_ADDR_INVERTED_REVISION: rdata_next = ~`OMS_SILICON_REV_VALUE;
        `OMS_ADDR_NVM_CLOCK_SETTING: rdata_next = nvm_clock_setting;
        `OMS_ADDR_NVM_CONFIGURATION: rdata_next = nvm_configuration;
        `OMS_ADDR_NVM_ADDRESS: rdata_next = nvm_address;
        `OMS_ADDR_NVM_WRITE_DATA: rdata_next = nvm_write_data;
        `OMS_ADDR_NVM_CONTROL: rdata_next = nvm_control;
        `OMS_ADDR_NVM_RUN_STATUS: rdata_next = nvm_run_status_in;
        `OMS_ADDR_NVM_CONTROL_STATUS: rdata_next = nvm_control_status_in;
        `OMS_ADDR_USE_PROGRAMMED: rdata_next = use_programmed_settings;
        `OMS_ADDR_RESOLUTION: rdata_next = resolution_setting;
        `OMS_ADDR_PRODUCT_CODE_HI: rdata_next = usb_product_code[15:8];
        `OMS_ADDR_PRODUCT_CODE_LO: rdata_next = usb_product_code[7:0];
        `OMS_ADDR_VENDOR_CODE_HI: rdata_next = usb_vendor_code[15:8];
        `OMS_ADDR_VENDOR_CODE_LO: rdata_next = usb_vendor_code[7:0];
        `OMS_ADDR_PROGRAMMING_LOCK: rdata_next = programming_lock;
        default: rdata_next = `OMS_RST_ZERO;
    endcase
end

////////////////////////////////////////////////////////////////////////
// answer path; reads served only while access is enabled
always @(posedge sys_clk) begin
    if (srst) begin
        reg_rdata <= `OMS_RST_ZERO;
        reg_rvalid <= 1'b0;
        reg_access_en <= 1'b0;
    end else begin
        reg_access_en <= main_supply_ok && !usb_bus_reset;
        reg_rvalid <= rd_ok;
        if (rd_ok) begin
            reg_rdata <= rdata_next;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// writable registers; writes to read-only offsets fall through
always @(posedge sys_clk) begin
    if (srst || usb_bus_reset) begin
        // bus reset returns configuration to defaults as a usb reset would
        nvm_clock_setting <= `OMS_RST_ZERO;
        nvm_configuration <= `OMS_RST_ZERO;
        nvm_address <= `OMS_RST_ZERO;
        nvm_write_data <= `OMS_RST_ZERO;
        nvm_control <= `OMS_RST_ZERO;
        use_programmed_settings <= `OMS_RST_ZERO;
        resolution_setting <= `OMS_RST_RESOLUTION;
        usb_product_code <= `OMS_PRODUCT_CODE_RESET;
        usb_vendor_code <= `OMS_VENDOR_CODE_RESET;
        programming_lock <= `OMS_RST_ZERO;
    end else if (wr_ok) begin
        case (reg_addr)
            `OMS_ADDR_NVM_CLOCK_SETTING: nvm_clock_setting <= reg_wdata;
            `OMS_ADDR_NVM_CONFIGURATION: nvm_configuration <= reg_wdata;
            `OMS_ADDR_NVM_ADDRESS: nvm_address <= reg_wdata;
            `OMS_ADDR_NVM_WRITE_DATA: nvm_write_data <= reg_wdata;
            `OMS_ADDR_NVM_CONTROL: nvm_control <= reg_wdata;
            `OMS_ADDR_USE_PROGRAMMED: use_programmed_settings <= reg_wdata;
            `OMS_ADDR_RESOLUTION: resolution_setting <= reg_wdata;
            `OMS_ADDR_PRODUCT_CODE_HI: usb_product_code[15:8] <= reg_wdata;
            `OMS_ADDR_PRODUCT_CODE_LO: usb_product_code[7:0] <= reg_wdata;
            `OMS_ADDR_VENDOR_CODE_HI: usb_vendor_code[15:8] <= reg_wdata;
            `OMS_ADDR_VENDOR_CODE_LO: usb_vendor_code[7:0] <= reg_wdata;
            `OMS_ADDR_PROGRAMMING_LOCK: programming_lock <= reg_wdata;
            default: programming_lock <= programming_lock;
        endcase
    end
end

endmodule

// File: tb/oms_register_bank_chk.sv
/* port assertions of the register bank.
 assumes binding onto oms_register_bank, one clock domain. */
`include "oms_regs.vh"
module oms_register_bank_chk (
    // clock and reset
    input wire sys_clk,
    input wire srst,
    // requests
    input wire main_supply_ok,
    input wire usb_bus_reset,
    input wire reg_read,
    input wire reg_write,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    // answers
    input wire [7:0] reg_rdata,
    input wire reg_rvalid,
    input wire [7:0] resolution_setting,
    // sources
    input wire first_button_flag,
    input wire second_button_flag,
    input wire third_button_flag,
    input wire report_load,
    input wire [11:0] report_dx
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    wire ok = main_supply_ok & ~usb_bus_reset;
    wire take = reg_read & ok;
    reg armed_reg;
    // arming survives bus resets, only srst clears it
    always @(posedge sys_clk) armed_reg <= srst ? 1'b0 : armed_reg | (take & (reg_addr == 8'h03));
    ////////////////////////////////////////
    a_read_answer: assert property (take |=> reg_rvalid) else $error("read unanswered");
    a_refused_read: assert property (!take |=> !reg_rvalid) else $error("stray answer");
    a_product_identifier: assert property (take && reg_addr == 8'h00 |=> reg_rdata == `OMS_PRODUCT_ID_VALUE)
        else $error("bad product id");
    a_inv_revision: assert property (take && reg_addr == 8'h40 |=> reg_rdata == ~`OMS_SILICON_REV_VALUE)
        else $error("bad inverted revision");
    a_button_bits: assert property (take && reg_addr == 8'h02 |=>
        reg_rdata == {5'h00, $past(third_button_flag, 2), $past(second_button_flag, 2),
        $past(first_button_flag, 2)})
        else $error("bad button bits");
    a_rdata_hold: assert property (!reg_rvalid |-> $stable(reg_rdata)) else $error("rdata moved");
    a_wr_resolution: assert property (reg_write && ok && reg_addr == 8'hE0 |=>
        resolution_setting == $past(reg_wdata)) else $error("write lost");
    a_cfg_stable: assert property (!(reg_write && ok) && !usb_bus_reset |=> $stable(resolution_setting))
        else $error("config moved");
    a_unarmed_zero: assert property (take && !armed_reg && (reg_addr == 8'h04 || reg_addr == 8'h05)
        |=> reg_rdata == 8'h00) else $error("unarmed read not zero");
    a_x_mirror: assert property (report_load ##1 !report_load ##1
        (!report_load && take && reg_addr == 8'h03) |=> reg_rdata == $past(report_dx[7:0], 3))
        else $error("x low mismatch");
endmodule
bind oms_register_bank oms_register_bank_chk i_chk (.sys_clk(sys_clk), .srst(srst), .reg_read(reg_read),
    .main_supply_ok(main_supply_ok), .usb_bus_reset(usb_bus_reset), .reg_write(reg_write), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .resolution_setting(resolution_setting),
    .first_button_flag(first_button_flag), .second_button_flag(second_button_flag),
    .third_button_flag(third_button_flag), .report_load(report_load), .report_dx(report_dx));

// File: tb/oms_host_model.sv
/* host side issuing register reads and writes.
 assumes one calling process; strobes change at falling edges. */
module oms_host_model (
    // clock
    input wire sys_clk,
    // request
    output logic reg_read,
    output logic reg_write,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    // answer
    input wire [7:0] reg_rdata,
    input wire reg_rvalid
);
    timeunit 1ns;
    timeprecision 1ns;
    // registers used as a test aid only, no report polling
    initial begin
        reg_read = 1'b0;
        reg_write = 1'b0;
        reg_addr = 8'h5A;
        reg_wdata = 8'hA5;
    end
    ////////////////////////////////////////
    // idle address and data turn inverted so stale values never pass
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(negedge sys_clk);
        reg_read = 1'b1;
        reg_addr = a;
        // answer stands half a cycle after the taking edge; grab it before dropping
        @(negedge sys_clk);
        v = reg_rvalid;
        d = reg_rdata;
        reg_read = 1'b0;
        reg_addr = ~a;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] w);
        @(negedge sys_clk);
        reg_write = 1'b1;
        reg_addr = a;
        reg_wdata = w;
        @(negedge sys_clk);
        reg_write = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~w;
    endtask
endmodule

// File: tb/oms_register_bank_tb.sv
/* self-checking bench of the register bank.
 assumes the host model carries every register request. */
module oms_register_bank_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic main_supply_ok = 1'b1;
    logic usb_bus_reset = 1'b0;
    logic report_load = 1'b0;
    logic [2:0] btn = 3'h0;
    logic [11:0] dx = 12'h000;
    logic [11:0] dy = 12'h000;
    logic [7:0] st = 8'hF0;
    logic reg_read, reg_write, reg_rvalid, access_en, v;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, resol, d;
    logic [15:0] vendor, prod;
    int bad_count = 0;
    int compares = 0;
    int cyc = 0;
    logic [7:0] ra [14] = '{8'h00, 8'h01, 8'h40, 8'h04, 8'h05, 8'hE0, 8'hE2, 8'hE3, 8'hE4, 8'hE5, 8'hDF, 8'hE8, 8'h42, 8'h30};
    logic [7:0] rv [14] = '{8'h5A, 8'h03, 8'hFC, 8'h00, 8'h00, 8'h04, 8'h12, 8'h34, 8'hAB, 8'hCD, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] sa [10] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h56, 8'h58};
    logic [7:0] wa [12] = '{8'h42, 8'h51, 8'h52, 8'h53, 8'h54, 8'hDF, 8'hE0, 8'hE2, 8'hE3, 8'hE4, 8'hE5, 8'hE8};
    oms_host_model i_host (.sys_clk(sys_clk), .reg_read(reg_read), .reg_write(reg_write), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
    // live inputs hang off st so each reads back a distinct value
    oms_register_bank i_dut (.sys_clk(sys_clk), .srst(srst), .main_supply_ok(main_supply_ok),
        .usb_bus_reset(usb_bus_reset), .reg_read(reg_read), .reg_write(reg_write), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_access_en(access_en),
        .first_button_flag(btn[0]), .second_button_flag(btn[1]), .third_button_flag(btn[2]),
        .report_load(report_load), .report_dx(dx), .report_dy(dy), .wheel_in(st ^ 8'h06),
        .surface_quality_in(st ^ 8'h07), .exposure_in({st ^ 8'h08, st ^ 8'h09}), .pixel_maximum_in(st ^ 8'h0A),
        .pixel_accumulation_in(st ^ 8'h0B), .pixel_minimum_in(st ^ 8'h0C), .pixel_capture_in(st ^ 8'h0D),
        .nvm_run_status_in(st ^ 8'h56), .nvm_control_status_in(st ^ 8'h58), .resolution_setting(resol),
        .use_programmed_settings(), .usb_product_code(prod), .usb_vendor_code(vendor), .programming_lock(),
        .nvm_clock_setting(), .nvm_configuration(), .nvm_address(), .nvm_write_data(), .nvm_control());
    ////////////////////////////////////////
    initial forever #20 sys_clk = ~sys_clk;
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        i_host.rd(a, d, v);
        chk({15'h0000, v}, 16'h0001);
        chk({8'h00, d}, {8'h00, e});
    endtask
    // x low is read first so the other two are armed
    task automatic mv(input logic [11:0] x, input logic [11:0] y);
        @(negedge sys_clk);
        report_load = 1'b1;
        dx = x;
        dy = y;
        @(negedge sys_clk);
        report_load = 1'b0;
        rdc(8'h03, x[7:0]);
        rdc(8'h04, y[7:0]);
        rdc(8'h05, {x[11:8], y[11:8]});
    endtask
    task give_verdict;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            give_verdict();
        end
    end
    initial begin
        repeat (2) @(negedge sys_clk);
        srst = 1'b0;
        for (int i = 0; i < 14; i++) rdc(ra[i], rv[i]);
        for (int i = 0; i < 10; i++) rdc(sa[i], (st ^ sa[i]) & (sa[i] == 8'h0A ? 8'h7F : 8'hFF));
        $display("test reset and live values done");
        for (int b = 0; b < 8; b++) begin
            btn = b[2:0];
            rdc(8'h02, {5'h00, btn});
        end
        $display("test buttons done");
        for (int i = 0; i < 12; i++) i_host.wr(wa[i], wa[i] ^ 8'h5C);
        for (int i = 0; i < 12; i++) rdc(wa[i], wa[i] ^ 8'h5C);
        chk(vendor, {8'hE4 ^ 8'h5C, 8'hE5 ^ 8'h5C});
        chk(prod, {8'hE2 ^ 8'h5C, 8'hE3 ^ 8'h5C});
        chk({8'h00, resol}, {8'h00, 8'hE0 ^ 8'h5C});
        i_host.wr(8'h01, 8'hFF);
        rdc(8'h01, 8'h03);
        $display("test write access done");
        mv(12'hF85, 12'h123);
        mv(12'h07F, 12'hF00);
        $display("test motion done");
        main_supply_ok = 1'b0;
        i_host.rd(8'h00, d, v);
        chk({15'h0000, v}, 16'h0000);
        chk({15'h0000, access_en}, 16'h0000);
        i_host.wr(8'hE0, 8'h77);
        main_supply_ok = 1'b1;
        rdc(8'hE0, 8'hE0 ^ 8'h5C);
        chk({15'h0000, access_en}, 16'h0001);
        usb_bus_reset = 1'b1;
        i_host.rd(8'h00, d, v);
        chk({15'h0000, v}, 16'h0000);
        usb_bus_reset = 1'b0;
        rdc(8'hE0, 8'h04);
        $display("test access disable done");
        give_verdict();
    end
endmodule
